// [logic/srlp_pkg.sv]
// constants, register map and state types shared by the reset and low-power controller
package srlp_pkg;
    // bus geometry
    localparam int unsigned ADDR_W = 8;
    localparam int unsigned DATA_W = 32;

    // register byte offsets
    localparam logic [7:0] ADDR_CTRL   = 8'h00;  // low-power options
    localparam logic [7:0] ADDR_SRST   = 8'h04;  // soft-reset request
    localparam logic [7:0] ADDR_STATUS = 8'h08;  // levels and activity
    localparam logic [7:0] ADDR_IRQ    = 8'h0C;  // interrupt flag, write one to clear

    // control register fields
    localparam int unsigned CTRL_LOWPWR_BIT = 0;  // request quiescence while idle
    localparam int unsigned CTRL_KEEPCLK_BIT = 1; // keep clock requested while stopped
    localparam logic [1:0]  CTRL_RESET = 2'h0;

    // soft-reset register fields
    localparam int unsigned SRST_GO_BIT   = 0;    // start the sequence
    localparam int unsigned SRST_PRIV_BIT = 1;    // requested privilege after reset
    localparam int unsigned SRST_NS_BIT   = 2;    // requested non-secure after reset

    // status register fields
    localparam int unsigned STAT_PRIV_BIT  = 0;
    localparam int unsigned STAT_NS_BIT    = 1;
    localparam int unsigned STAT_BUSY_BIT  = 2;
    localparam int unsigned STAT_IRQ_BIT   = 3;
    localparam int unsigned STAT_TASK_BIT  = 4;
    localparam int unsigned STAT_QUEUE_BIT = 5;

    // interrupt register fields
    localparam int unsigned IRQ_DONE_BIT = 0;

    // internal reset held this many cycles
    localparam logic [1:0] RST_ASSERT_CYCLES = 2'h2;

    // soft-reset sequencer
    typedef enum logic [2:0] {
        SEQ_IDLE    = 3'b000,
        SEQ_DMA     = 3'b001,
        SEQ_ASSERT  = 3'b010,
        SEQ_RELEASE = 3'b011,
        SEQ_RAMCLR  = 3'b100,
        SEQ_UPDATE  = 3'b101
    } srlp_seq_e;

    // quiescence handshake
    typedef enum logic [1:0] {
        QCH_RUN     = 2'b00,
        QCH_STOPPED = 2'b01,
        QCH_DENIED  = 2'b10
    } srlp_qch_e;
endpackage

// [logic/srlp_qch.sv]
// one quiescence handshake slave, used for clock and for power
`timescale 1ns/1ps
`default_nettype none
module srlp_qch
(
    // clock and reset
    input  wire logic clk,
    input  wire logic resetn,
    // device side
    input  wire logic allowQuiesce,
    input  wire logic wantActive,
    // controller side
    input  wire logic qreqn,
    output var  logic qacceptn,
    output var  logic qdeny,
    output var  logic qactive
);
    import srlp_pkg::*;

    srlp_qch_e state_reg;  // handshake phase

    // request, accept and deny sequence; accept only when quiescence allowed
    always_ff @(posedge clk or negedge resetn)
    begin
        if (!resetn)
        begin
            state_reg <= QCH_RUN;
            qacceptn  <= 1'b1;
            qdeny     <= 1'b0;
        end
        else
        begin
            case (state_reg)
                QCH_RUN:
                begin
                    if (!qreqn && allowQuiesce)
                    begin
                        state_reg <= QCH_STOPPED;
                        qacceptn  <= 1'b0;
                    end
                    else if (!qreqn)
                    begin
                        state_reg <= QCH_DENIED;
                        qdeny     <= 1'b1;
                    end
                end
                QCH_STOPPED:
                begin
                    // controller restores the clock or power before raising qreqn
                    if (qreqn)
                    begin
                        state_reg <= QCH_RUN;
                        qacceptn  <= 1'b1;
                    end
                end
                QCH_DENIED:
                begin
                    if (qreqn)
                    begin
                        state_reg <= QCH_RUN;
                        qdeny     <= 1'b0;
                    end
                end
                default:
                begin
                    state_reg <= QCH_RUN;
                    qacceptn  <= 1'b1;
                    qdeny     <= 1'b0;
                end
            endcase
        end
    end

    // activity hint registered so the port is glitch free
    always_ff @(posedge clk or negedge resetn)
    begin
        if (!resetn)
            qactive <= 1'b1;
        else
            qactive <= wantActive;
    end

    acceptAllowed_a: assert property (
        @(posedge clk) disable iff (!resetn)
        $fell(qacceptn) |-> $past(allowQuiesce) && !$past(qreqn))
        else $error("quiescence accepted while not allowed");

    denyRefused_a: assert property (
        @(posedge clk) disable iff (!resetn)
        (state_reg == QCH_RUN && !qreqn && !allowQuiesce) |=> qdeny && qacceptn)
        else $error("refused quiescence not denied");
endmodule
`default_nettype wire

// [logic/srlp_ctrl.sv]
// boot straps, access checks, soft-reset sequencing and quiescence control
//
// Chosen here: the placing of the registers and the Wishbone register port.
`timescale 1ns/1ps
`default_nettype none
module srlp_ctrl
(
    // clock and reset
    input  wire logic                         clk,
    input  wire logic                         resetn,
    // wishbone slave with protection sideband
    input  wire logic                         wbCyc,
    input  wire logic                         wbStb,
    input  wire logic                         wbWe,
    input  wire logic [srlp_pkg::ADDR_W-1:0]  wbAdr,
    input  wire logic [3:0]                   wbSel,
    input  wire logic [srlp_pkg::DATA_W-1:0]  wbDatW,
    input  wire logic [2:0]                   wbProt,
    output var  logic [srlp_pkg::DATA_W-1:0]  wbDatR,
    output var  logic                         wbAck,
    // boot straps
    input  wire logic                         bootPrivilegeStrap,
    input  wire logic                         bootSecurityStrap,
    // core activity
    input  wire logic                         taskActive,
    input  wire logic                         queuePending,
    input  wire logic                         cmdQueueEmpty,
    input  wire logic                         coreStopped,
    input  wire logic                         jobDone,
    output var  logic                         irqOut,
    // memory masters
    input  wire logic                         axiBusy,
    output var  logic [2:0]                   arprot,
    output var  logic [2:0]                   awprot,
    // reset sequencing
    output var  logic                         dmaResetReq,
    input  wire logic                         dmaResetAck,
    output var  logic                         coreClkEn,
    output var  logic                         sysRstn,
    output var  logic                         ramClearReq,
    input  wire logic                         ramClearDone,
    // clock quiescence
    input  wire logic                         clkQreqn,
    output var  logic                         clkQacceptn,
    output var  logic                         clkQdeny,
    output var  logic                         clkQactive,
    // power quiescence
    input  wire logic                         pwrQreqn,
    output var  logic                         pwrQacceptn,
    output var  logic                         pwrQdeny,
    output var  logic                         pwrQactive
);
    import srlp_pkg::*;

    srlp_seq_e  seq_reg;                 // soft-reset sequencer
    logic [1:0] rstCnt_reg;              // cycles of internal reset
    logic       strapTaken_reg;          // straps captured since hard reset
    logic       currentPrivilegeLevel_reg;
    logic       currentNonsecureFlag_reg;
    logic       pendPriv_reg;            // levels to apply after soft reset
    logic       pendNs_reg;
    logic [1:0] ctrl_reg;                // low-power options
    logic       wbReq;                   // new bus request this cycle
    logic       wbWr;                    // new write this cycle
    logic       accessOk;                // protection permits the access
    logic       srstGo;                  // accepted soft-reset request
    logic       irqClr;                  // software clears the flag
    logic       idle;                    // nothing to do
    logic       quiesceOk;               // quiescence may be accepted
    logic       lowPwrWanted;            // ask controllers to quiesce

    // bus decode; ack drops the cycle after it is given
    assign wbReq  = wbCyc && wbStb && !wbAck;
    assign wbWr   = wbReq && wbWe && wbSel[0];
    // privilege at least current, non-secure not above current
    assign accessOk = (wbProt[0] >= currentPrivilegeLevel_reg) &&
                      (wbProt[1] <= currentNonsecureFlag_reg);
    assign srstGo = wbWr && (wbAdr == ADDR_SRST) && wbDatW[SRST_GO_BIT] &&
                    accessOk && (seq_reg == SEQ_IDLE);
    assign irqClr = wbWr && (wbAdr == ADDR_IRQ) && wbDatW[IRQ_DONE_BIT];

    // bus answer, one cycle after the request; unmapped reads give zero
    always_ff @(posedge clk or negedge resetn)
    begin
        if (!resetn)
        begin
            wbAck  <= 1'b0;
            wbDatR <= 32'h00000000;
        end
        else
        begin
            wbAck  <= wbReq;
            wbDatR <= 32'h00000000;
            if (wbReq && !wbWe)
            begin
                case (wbAdr)
                    ADDR_CTRL:   wbDatR[1:0] <= ctrl_reg;
                    ADDR_STATUS:
                    begin
                        wbDatR[STAT_PRIV_BIT]  <= currentPrivilegeLevel_reg;
                        wbDatR[STAT_NS_BIT]    <= currentNonsecureFlag_reg;
                        wbDatR[STAT_BUSY_BIT]  <= (seq_reg != SEQ_IDLE);
                        wbDatR[STAT_IRQ_BIT]   <= irqOut;
                        wbDatR[STAT_TASK_BIT]  <= taskActive;
                        wbDatR[STAT_QUEUE_BIT] <= queuePending;
                    end
                    ADDR_IRQ:    wbDatR[IRQ_DONE_BIT] <= irqOut;
                    default:     wbDatR <= 32'h00000000;
                endcase
            end
        end
    end

    // control options; wiped while the internal reset is applied
    always_ff @(posedge clk or negedge resetn)
    begin
        if (!resetn)
            ctrl_reg <= CTRL_RESET;
        else if (seq_reg == SEQ_ASSERT)
            ctrl_reg <= CTRL_RESET;
        else if (wbWr && wbAdr == ADDR_CTRL && accessOk)
            ctrl_reg <= wbDatW[1:0];
    end

    // completion flag; a new completion beats a clear in the same cycle
    always_ff @(posedge clk or negedge resetn)
    begin
        if (!resetn)
            irqOut <= 1'b0;
        else if (jobDone)
            irqOut <= 1'b1;
        else if (seq_reg == SEQ_ASSERT)
            irqOut <= 1'b0;
        else if (irqClr && accessOk)
            irqOut <= 1'b0;
    end

    // requested levels, capped by the requester's own protection
    always_ff @(posedge clk or negedge resetn)
    begin
        if (!resetn)
        begin
            pendPriv_reg <= 1'b0;
            pendNs_reg   <= 1'b1;
        end
        else if (srstGo)
        begin
            pendPriv_reg <= wbDatW[SRST_PRIV_BIT] & wbProt[0];
            pendNs_reg   <= wbDatW[SRST_NS_BIT] | wbProt[1];
        end
    end

    // current levels: straps after hard reset, pending after soft reset
    always_ff @(posedge clk or negedge resetn)
    begin
        if (!resetn)
        begin
            strapTaken_reg            <= 1'b0;
            currentPrivilegeLevel_reg <= 1'b0;
            currentNonsecureFlag_reg  <= 1'b1;
        end
        else if (!strapTaken_reg)
        begin
            // caught after release, never through the async reset
            strapTaken_reg            <= 1'b1;
            currentPrivilegeLevel_reg <= bootPrivilegeStrap;
            currentNonsecureFlag_reg  <= bootSecurityStrap;
        end
        else if (seq_reg == SEQ_UPDATE)
        begin
            currentPrivilegeLevel_reg <= pendPriv_reg;
            currentNonsecureFlag_reg  <= pendNs_reg;
        end
    end

    // memory-bus protection: data access, with the current non-secure and privilege levels
    always_ff @(posedge clk or negedge resetn)
    begin
        if (!resetn)
        begin
            arprot <= 3'h2;
            awprot <= 3'h2;
        end
        else
        begin
            arprot <= {1'b0, currentNonsecureFlag_reg, currentPrivilegeLevel_reg};
            awprot <= {1'b0, currentNonsecureFlag_reg, currentPrivilegeLevel_reg};
        end
    end

    // soft-reset sequence: notify DMA, drain, reset, clear RAMs, update
    always_ff @(posedge clk or negedge resetn)
    begin
        if (!resetn)
        begin
            seq_reg     <= SEQ_IDLE;
            rstCnt_reg  <= 2'h0;
            dmaResetReq <= 1'b0;
            coreClkEn   <= 1'b1;
            sysRstn     <= 1'b1;
            ramClearReq <= 1'b0;
        end
        else
        begin
            case (seq_reg)
                SEQ_IDLE:
                begin
                    if (srstGo)
                    begin
                        seq_reg     <= SEQ_DMA;
                        dmaResetReq <= 1'b1;
                    end
                end
                SEQ_DMA:
                begin
                    // masters must be quiet before the reset cuts them
                    if (dmaResetAck && !axiBusy)
                    begin
                        seq_reg     <= SEQ_ASSERT;
                        dmaResetReq <= 1'b0;
                        coreClkEn   <= 1'b0;
                        sysRstn     <= 1'b0;
                        rstCnt_reg  <= 2'h1;
                    end
                end
                SEQ_ASSERT:
                begin
                    if (rstCnt_reg >= RST_ASSERT_CYCLES)
                    begin
                        seq_reg <= SEQ_RELEASE;
                        sysRstn <= 1'b1;
                    end
                    else
                        rstCnt_reg <= rstCnt_reg + 2'h1;
                end
                SEQ_RELEASE:
                begin
                    // RAM clearing needs the clock back
                    seq_reg     <= SEQ_RAMCLR;
                    coreClkEn   <= 1'b1;
                    ramClearReq <= 1'b1;
                end
                SEQ_RAMCLR:
                begin
                    if (ramClearDone)
                    begin
                        seq_reg     <= SEQ_UPDATE;
                        ramClearReq <= 1'b0;
                    end
                end
                SEQ_UPDATE:
                    seq_reg <= SEQ_IDLE;
                default:
                begin
                    seq_reg     <= SEQ_IDLE;
                    dmaResetReq <= 1'b0;
                    coreClkEn   <= 1'b1;
                    sysRstn     <= 1'b1;
                    ramClearReq <= 1'b0;
                end
            endcase
        end
    end

    // quiescence policy; pending work also refuses, at some cost in savings
    assign idle = cmdQueueEmpty || coreStopped;
    assign quiesceOk = !taskActive && !queuePending &&
                       (seq_reg == SEQ_IDLE) && strapTaken_reg;
    assign lowPwrWanted = ctrl_reg[CTRL_LOWPWR_BIT] && idle && quiesceOk;

    // clock channel; the clock stays free running unless accepted here
    srlp_qch clkChan
    (
        .clk          (clk),
        .resetn       (resetn),
        .allowQuiesce (quiesceOk && !(ctrl_reg[CTRL_KEEPCLK_BIT] && coreStopped)),
        .wantActive   (!lowPwrWanted || (ctrl_reg[CTRL_KEEPCLK_BIT] && coreStopped)),
        .qreqn        (clkQreqn),
        .qacceptn     (clkQacceptn),
        .qdeny        (clkQdeny),
        .qactive      (clkQactive)
    );

    // power channel, independent of the clock channel
    srlp_qch pwrChan
    (
        .clk          (clk),
        .resetn       (resetn),
        .allowQuiesce (quiesceOk),
        .wantActive   (!lowPwrWanted),
        .qreqn        (pwrQreqn),
        .qacceptn     (pwrQacceptn),
        .qdeny        (pwrQdeny),
        .qactive      (pwrQactive)
    );

    strapPriv_a: assert property (
        @(posedge clk) disable iff (!resetn)
        $rose(strapTaken_reg) |-> currentPrivilegeLevel_reg == $past(bootPrivilegeStrap))
        else $error("privilege strap not captured");

    strapSec_a: assert property (
        @(posedge clk) disable iff (!resetn)
        $rose(strapTaken_reg) |-> currentNonsecureFlag_reg == $past(bootSecurityStrap))
        else $error("security strap not captured");

    levelCap_a: assert property (
        @(posedge clk) disable iff (!resetn)
        srstGo |=> (pendPriv_reg <= $past(wbProt[0])) && (pendNs_reg >= $past(wbProt[1])))
        else $error("soft reset raises level above requester");

    resetWipe_a: assert property (
        @(posedge clk) disable iff (!resetn)
        (seq_reg == SEQ_ASSERT && !jobDone) |=> ctrl_reg == CTRL_RESET && !irqOut)
        else $error("registers survive soft reset");

    drainWait_a: assert property (
        @(posedge clk) disable iff (!resetn)
        (seq_reg == SEQ_DMA && axiBusy) |=> seq_reg == SEQ_DMA && sysRstn)
        else $error("reset applied with bus traffic outstanding");

    protRefuse_a: assert property (
        @(posedge clk) disable iff (!resetn)
        (wbWr && wbAdr == ADDR_SRST && !accessOk && seq_reg == SEQ_IDLE) |=> seq_reg == SEQ_IDLE)
        else $error("unpermitted soft reset accepted");

    dmaHold_a: assert property (
        @(posedge clk) disable iff (!resetn)
        (seq_reg == SEQ_DMA && !dmaResetAck) |=> seq_reg == SEQ_DMA && dmaResetReq)
        else $error("reset advanced without DMA acknowledge");

    rstPulse_a: assert property (
        @(posedge clk) disable iff (!resetn)
        $fell(sysRstn) |-> !coreClkEn ##1 (!sysRstn && !coreClkEn) ##1 sysRstn ##1 ramClearReq)
        else $error("internal reset not two cycles then RAM clear");

    axiLevel_a: assert property (
        @(posedge clk) disable iff (!resetn)
        $changed(currentNonsecureFlag_reg) |=> arprot[1] == currentNonsecureFlag_reg && awprot == arprot)
        else $error("memory protection does not follow level");

    irqWins_a: assert property (
        @(posedge clk) disable iff (!resetn)
        jobDone |=> irqOut)
        else $error("completion lost");

    busyRefuse_a: assert property (
        @(posedge clk) disable iff (!resetn)
        taskActive |=> clkQacceptn && pwrQacceptn)
        else $error("quiescence accepted during task");
endmodule
`default_nettype wire

// [tb/srlp_far_model.sv]
// far side model: dma reset acknowledge and ram clear completion
`timescale 1ns/1ps
`default_nettype none
module srlp_far_model
#(
    parameter int DLY = 3  // answer latency in cycles
)
(
    // clock and reset
    input  wire logic clk,
    input  wire logic resetn,
    // reset handshakes
    input  wire logic dmaResetReq,
    output wire logic dmaResetAck,
    input  wire logic ramClearReq,
    output wire logic ramClearDone
);
    logic [3:0] dmaCnt_reg;  // cycles the drain request has stood
    logic [3:0] ramCnt_reg;  // cycles the clear request has stood
    // counters saturate so a long stall never drops an answer
    always_ff @(posedge clk or negedge resetn)
    begin
        if (!resetn)
        begin
            dmaCnt_reg <= 4'h0;
            ramCnt_reg <= 4'h0;
        end
        else
        begin
            dmaCnt_reg <= dmaResetReq ? dmaCnt_reg + {3'h0, dmaCnt_reg != 4'hF} : 4'h0;
            ramCnt_reg <= ramClearReq ? ramCnt_reg + {3'h0, ramCnt_reg != 4'hF} : 4'h0;
        end
    end
    // answers fall with their request, never kinder than that
    assign dmaResetAck  = dmaResetReq && (dmaCnt_reg >= DLY);
    assign ramClearDone = ramClearReq && (ramCnt_reg >= DLY);
endmodule
`default_nettype wire

// [tb/srlp_ctrl_tb.sv]
// self-checking bench for the reset and low-power controller
`timescale 1ns/1ps
`default_nettype none
`define CHK(a, e) begin checks++; if ((a) !== (e)) begin n_fail++; $display("BAD %0t got %0h want %0h", $time, a, e); end end
module srlp_ctrl_tb;
    import srlp_pkg::*;
    // design inputs, with the read data and memory-bus protection outputs
    logic clk, resetn, wbCyc, wbStb, wbWe, jobDone, taskActive, queuePending;
    logic cmdQueueEmpty, coreStopped, axiBusy, clkQreqn, pwrQreqn;
    logic bootPrivilegeStrap, bootSecurityStrap, dmaResetAck, ramClearDone;
    logic [7:0] wbAdr;
    logic [3:0] wbSel;
    logic [31:0] wbDatW, wbDatR, rd;
    logic [2:0] wbProt, arprot, awprot;
    // design outputs
    logic wbAck, irqOut, dmaResetReq, coreClkEn, sysRstn, ramClearReq;
    logic clkQacceptn, clkQdeny, clkQactive, pwrQacceptn, pwrQdeny, pwrQactive;
    int n_fail = 0;
    int checks = 0;
    int cyc = 0;
    srlp_ctrl dut_u (.clk, .resetn, .wbCyc, .wbStb, .wbWe, .wbAdr, .wbSel, .wbDatW, .wbProt, .wbDatR,
        .wbAck, .bootPrivilegeStrap, .bootSecurityStrap, .taskActive, .queuePending, .cmdQueueEmpty,
        .coreStopped, .jobDone, .irqOut, .axiBusy, .arprot, .awprot, .dmaResetReq, .dmaResetAck,
        .coreClkEn, .sysRstn, .ramClearReq, .ramClearDone, .clkQreqn, .clkQacceptn, .clkQdeny,
        .clkQactive, .pwrQreqn, .pwrQacceptn, .pwrQdeny, .pwrQactive);
    srlp_far_model #(.DLY(3)) far_u (.clk, .resetn, .dmaResetReq, .dmaResetAck, .ramClearReq, .ramClearDone);
    // free-running clock, never gated here
    initial
    begin
        clk = 1'b0;
        forever #2 clk = ~clk;
    end
    // verdict and end of run
    task automatic wrap_up();
        if (n_fail == 0 && checks > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask
    // hang guard
    always @(posedge clk)
    begin
        cyc++;
        if (cyc == 20000)
        begin
            n_fail++;
            wrap_up();
        end
    end
    // classic single cycle; ack and read data taken at the rising edge, released right after it
    task automatic wb(input logic we, input logic [7:0] a, input logic [31:0] d, input logic [2:0] p,
                      output logic [31:0] r);
        int n;
        @(posedge clk);
        wbCyc <= 1'b1;
        wbStb <= 1'b1;
        wbWe <= we;
        wbAdr <= a;
        wbDatW <= d;
        wbProt <= p;
        n = 0;
        do
        begin
            @(posedge clk);
            n++;
        end
        while (wbAck !== 1'b1 && n < 20);
        if (wbAck !== 1'b1)
            n_fail++;
        r = wbDatR;
        wbCyc <= 1'b0;
        wbStb <= 1'b0;
    endtask
    // both quiescence channels at once; e = {clock denies, power denies}
    task automatic t_q(input logic [1:0] e);
        @(posedge clk);
        clkQreqn <= 1'b0;
        pwrQreqn <= 1'b0;
        repeat (2) @(negedge clk);
        `CHK({clkQdeny, clkQacceptn, pwrQdeny, pwrQacceptn}, {e[1], e[1], e[0], e[0]})
        @(posedge clk);
        clkQreqn <= 1'b1;
        pwrQreqn <= 1'b1;
        repeat (2) @(negedge clk);
        `CHK({clkQdeny, clkQacceptn, pwrQdeny, pwrQacceptn}, 4'h5)
    endtask
    // strap levels and bus attributes after power-up
    task automatic t_boot();
        wb(1'b0, ADDR_STATUS, 32'h0, 3'h0, rd);
        `CHK(rd[1:0], 2'h1)
        `CHK({arprot, awprot}, 6'h09)
        wb(1'b0, 8'h40, 32'h0, 3'h0, rd);
        `CHK(rd, 32'h0)
    endtask
    // completion flag: set, refused clear, clear
    task automatic t_irq();
        @(posedge clk);
        jobDone <= 1'b1;
        @(posedge clk);
        jobDone <= 1'b0;
        @(negedge clk);
        `CHK(irqOut, 1'b1)
        wb(1'b1, ADDR_IRQ, 32'h1, 3'h0, rd);
        @(negedge clk);
        `CHK(irqOut, 1'b1)
        wb(1'b1, ADDR_IRQ, 32'h1, 3'h1, rd);
        @(negedge clk);
        `CHK(irqOut, 1'b0)
    endtask
    // busy task, pending queue, then idle
    task automatic t_qch();
        for (int k = 0; k < 3; k++)
        begin
            @(posedge clk);
            taskActive <= (k == 0);
            queuePending <= (k == 1);
            t_q({k < 2, k < 2});
        end
    endtask
    // idle low-power requests and the keep-clock option
    task automatic t_lp();
        wb(1'b1, ADDR_CTRL, 32'h1, 3'h1, rd);
        cmdQueueEmpty <= 1'b1;
        repeat (3) @(negedge clk);
        `CHK({clkQactive, pwrQactive}, 2'h0)
        @(posedge clk);
        cmdQueueEmpty <= 1'b0;
        repeat (3) @(negedge clk);
        `CHK({clkQactive, pwrQactive}, 2'h3)
        wb(1'b1, ADDR_CTRL, 32'h3, 3'h1, rd);
        coreStopped <= 1'b1;
        repeat (3) @(negedge clk);
        `CHK({clkQactive, pwrQactive}, 2'h2)
        t_q(2'h2);
    endtask
    // soft reset writes lacking privilege or marked non-secure are dropped
    task automatic t_srst_bad();
        wb(1'b1, ADDR_SRST, 32'h1, 3'h0, rd);
        wb(1'b1, ADDR_SRST, 32'h1, 3'h3, rd);
        repeat (3) @(negedge clk);
        `CHK({dmaResetReq, sysRstn}, 2'h1)
    endtask
    // full soft reset with traffic outstanding; lv = {nonsecure, privilege} expected
    task automatic t_srst(input logic [2:0] d, input logic [2:0] p, input logic [1:0] lv);
        int n;
        @(posedge clk);
        axiBusy <= 1'b1;
        jobDone <= 1'b1;
        @(posedge clk);
        jobDone <= 1'b0;
        wb(1'b1, ADDR_SRST, {29'h0, d}, p, rd);
        repeat (8) @(negedge clk);
        `CHK({dmaResetReq, sysRstn}, 2'h3)
        @(posedge clk);
        axiBusy <= 1'b0;
        n = 0;
        while (sysRstn !== 1'b0 && n < 20)
        begin
            @(negedge clk);
            n++;
        end
        `CHK({coreClkEn, dmaResetReq}, 2'h0)
        @(negedge clk);
        `CHK(sysRstn, 1'b0)
        @(negedge clk);
        `CHK({sysRstn, coreClkEn}, 2'h2)
        n = 0;
        do
        begin
            wb(1'b0, ADDR_STATUS, 32'h0, p, rd);
            n++;
        end
        while (rd[2] !== 1'b0 && n < 20);
        `CHK({rd[3], rd[1:0]}, {1'b0, lv})
        wb(1'b0, ADDR_CTRL, 32'h0, p, rd);
        `CHK(rd[1:0], 2'h0)
        `CHK(arprot, {1'b0, lv})
    endtask
    // main sequence
    initial
    begin
        {wbCyc, wbStb, wbWe, jobDone, taskActive, queuePending, resetn} = 7'h0;
        {cmdQueueEmpty, coreStopped, axiBusy, bootSecurityStrap} = 4'h0;
        {clkQreqn, pwrQreqn, bootPrivilegeStrap} = 3'h7;
        wbAdr = 8'h0;
        wbDatW = 32'h0;
        wbProt = 3'h0;
        wbSel = 4'hF;
        repeat (4) @(posedge clk);
        resetn <= 1'b1;
        repeat (2) @(posedge clk);
        t_boot();
        t_irq();
        t_qch();
        t_lp();
        t_srst_bad();
        t_srst(3'h5, 3'h1, 2'h2);
        t_srst(3'h3, 3'h2, 2'h2);
        wrap_up();
    end
endmodule
`default_nettype wire
